// file: core/bkpt_status_ctrl.sv
// Background debug controller status, breakpoint and force-reset registers.
// Assumes a serial command decoder presents one-cycle register strobes on mclk;
// CPU status inputs come from the same clock domain.
`timescale 1ns/1ps
module bkpt_status_ctrl (
    input wire logic mclk, // 50 MHz clock
    input wire logic rstn, // Async reset, active low
    // Serial register port
    input wire logic ser_wr, // Serial write strobe
    input wire logic ser_rd, // Serial read strobe
    input wire logic ser_bkpt_cmd, // Strobe comes from a breakpoint command
    input wire logic [bkpt_status_pkg::REG_IDX_W-1:0] ser_idx, // Register index
    input wire logic [bkpt_status_pkg::DATA_W-1:0] ser_wdata, // Write data
    output logic [bkpt_status_pkg::DATA_W-1:0] ser_rdata, // Read data
    output logic ser_rvalid, // Read data valid pulse
    // User program bus view of force-reset register
    input wire logic user_wr_force_reset, // User write attempt, ignored
    // CPU status
    input wire logic cpu_lowpower, // CPU in wait or stop
    input wire logic bg_entry, // Background command entered active background
    input wire logic bg_exit, // Return to user program
    input wire logic access_fail_lowpower, // Access failed on wait/stop
    input wire logic access_fail_slow, // Access failed on slow access
    input wire logic access_start, // New memory access command starts
    // Breakpoint compare
    input wire logic [bkpt_status_pkg::ADDR_W-1:0] cpu_addr, // CPU address bus
    input wire logic cpu_fetch, // Opcode fetch cycle
    input wire logic cpu_boundary, // Instruction boundary
    input wire logic tagged_exec, // Tagged opcode reached execution
    output logic bkpt_force_req, // Force background at boundary
    output logic bkpt_tag, // Tag fetched opcode
    output logic bkpt_tag_enter, // Enter background for tagged opcode
    output logic mcu_reset_req // MCU reset request, active high
);
    import bkpt_status_pkg::*;

    // Breakpoint force sequencing: waiting for a match, or armed until a boundary
    typedef enum logic {BK_IDLE, BK_ARMED} bk_state_t;
    // Forced reset sequencing: quiet, or driving the MCU reset pulse
    typedef enum logic {RST_IDLE, RST_PULSE} rst_state_t;

    // Status and control state
    logic bkpt_en_ff;
    logic nxt_bkpt_en;
    logic force_tag_ff;
    logic nxt_force_tag;
    logic lp_hold_ff;
    logic nxt_lp_hold;
    logic lp_fail_ff;
    logic nxt_lp_fail;
    logic slow_fail_ff;
    logic nxt_slow_fail;
    // Breakpoint state and output pulses
    bk_state_t bk_state_ff;
    bk_state_t nxt_bk_state;
    logic bkpt_force_ff;
    logic nxt_bkpt_force;
    logic bkpt_tag_ff;
    logic nxt_bkpt_tag;
    logic tag_enter_ff;
    logic nxt_tag_enter;
    // Forced reset state
    rst_state_t rst_state_ff;
    rst_state_t nxt_rst_state;
    logic [3:0] rst_cnt_ff;
    logic [3:0] nxt_rst_cnt;
    logic rst_ff;
    logic nxt_rst;
    // Read port state
    logic [DATA_W-1:0] rdata_ff;
    logic [DATA_W-1:0] nxt_rdata;
    logic rvalid_ff;
    logic nxt_rvalid;
    // Decoded strobes and the breakpoint compare
    logic [DATA_W-1:0] pair_rdata;
    logic [ADDR_W-1:0] bkpt_addr;
    wire logic [ADDR_W/DATA_W-1:0] byte_eq;
    logic wr_high;
    logic wr_low;
    logic rd_pair;
    logic force_wr;
    logic match;

    // Index decode shared by every read and write path
    function automatic logic hit(input logic [REG_IDX_W-1:0] idx, input logic [REG_IDX_W-1:0] want);
        hit = (idx == want);
    endfunction

    // Pair is touched only by serial breakpoint commands, which run in the foreground too
    assign wr_high = ser_wr && ser_bkpt_cmd && hit(ser_idx, IDX_BKPT_HIGH);
    assign wr_low = ser_wr && ser_bkpt_cmd && hit(ser_idx, IDX_BKPT_LOW);
    assign rd_pair = ser_rd && ser_bkpt_cmd &&
        (hit(ser_idx, IDX_BKPT_HIGH) || hit(ser_idx, IDX_BKPT_LOW));
    // Only the serial path reaches the force-reset bit; the user write port goes nowhere
    assign force_wr = ser_wr && hit(ser_idx, IDX_FORCE_RESET) && ser_wdata[BIT_FORCE_RESET];

    // Address pair storage
    bkpt_pair_reg u_pair (
        .mclk(mclk),
        .rstn(rstn),
        .wr_high(wr_high),
        .wr_low(wr_low),
        .wdata(ser_wdata),
        .rd_low_sel(hit(ser_idx, IDX_BKPT_LOW)),
        .rdata(pair_rdata),
        .addr(bkpt_addr)
    );

    // Compare the address one byte at a time; a match needs every byte equal
    for (genvar g = 0; g < ADDR_W / DATA_W; g++) begin : g_byte_cmp
        assign byte_eq[g] = (cpu_addr[g*DATA_W +: DATA_W] == bkpt_addr[g*DATA_W +: DATA_W]);
    end
    assign match = &byte_eq;

    // Status and control bits
    always_comb begin
        nxt_bkpt_en = bkpt_en_ff;
        nxt_force_tag = force_tag_ff;
        nxt_lp_hold = lp_hold_ff;
        nxt_lp_fail = lp_fail_ff;
        nxt_slow_fail = slow_fail_ff;
        if (ser_wr && hit(ser_idx, IDX_STATUS_CONTROL)) begin
            nxt_bkpt_en = ser_wdata[BIT_BKPT_EN];
            nxt_force_tag = ser_wdata[BIT_FORCE_TAG];
        end
        // Remember a background entry from wait/stop until the program resumes
        if (bg_exit) begin
            nxt_lp_hold = 1'b0;
        end
        if (bg_entry && cpu_lowpower) begin
            nxt_lp_hold = 1'b1;
        end
        // Fail flags cleared when a new access starts; a failure in that cycle wins
        if (access_start) begin
            nxt_lp_fail = 1'b0;
            nxt_slow_fail = 1'b0;
        end
        if (access_fail_lowpower) begin
            nxt_lp_fail = 1'b1;
        end
        if (access_fail_slow) begin
            nxt_slow_fail = 1'b1;
        end
    end

    // Register the status and control bits
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            bkpt_en_ff <= 1'b0;
            force_tag_ff <= 1'b0;
            lp_hold_ff <= 1'b0;
            lp_fail_ff <= 1'b0;
            slow_fail_ff <= 1'b0;
        end else begin
            bkpt_en_ff <= nxt_bkpt_en;
            force_tag_ff <= nxt_force_tag;
            lp_hold_ff <= nxt_lp_hold;
            lp_fail_ff <= nxt_lp_fail;
            slow_fail_ff <= nxt_slow_fail;
        end
    end

    // Breakpoint sequencing; everything is held quiet while the enable is clear
    always_comb begin
        nxt_bk_state = bk_state_ff;
        nxt_bkpt_force = 1'b0;
        nxt_bkpt_tag = 1'b0;
        nxt_tag_enter = 1'b0;
        if (!bkpt_en_ff) begin
            nxt_bk_state = BK_IDLE;
        end else if (force_tag_ff) begin
            // A match may fall on any address; the force waits for the next boundary
            case (bk_state_ff)
                BK_IDLE: begin
                    if (match && cpu_boundary) begin
                        nxt_bkpt_force = 1'b1;
                    end else if (match) begin
                        nxt_bk_state = BK_ARMED;
                    end
                end
                BK_ARMED: begin
                    if (cpu_boundary) begin
                        nxt_bkpt_force = 1'b1;
                        nxt_bk_state = BK_IDLE;
                    end
                end
                default: begin
                    nxt_bk_state = BK_IDLE;
                end
            endcase
        end else begin
            // Tag mode: mark the fetched opcode, enter background only if it executes
            nxt_bk_state = BK_IDLE;
            nxt_bkpt_tag = match && cpu_fetch;
            nxt_tag_enter = tagged_exec;
        end
    end

    // Register the breakpoint state and its pulses
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            bk_state_ff <= BK_IDLE;
            bkpt_force_ff <= 1'b0;
            bkpt_tag_ff <= 1'b0;
            tag_enter_ff <= 1'b0;
        end else begin
            bk_state_ff <= nxt_bk_state;
            bkpt_force_ff <= nxt_bkpt_force;
            bkpt_tag_ff <= nxt_bkpt_tag;
            tag_enter_ff <= nxt_tag_enter;
        end
    end

    // Forced reset: a serial write of the bit starts a pulse of fixed length
    always_comb begin
        nxt_rst_state = rst_state_ff;
        nxt_rst_cnt = rst_cnt_ff;
        case (rst_state_ff)
            RST_IDLE: begin
                nxt_rst_cnt = 4'h0;
            end
            RST_PULSE: begin
                if (rst_cnt_ff != 4'h0) begin
                    nxt_rst_cnt = rst_cnt_ff - 4'h1;
                end else begin
                    nxt_rst_state = RST_IDLE;
                end
            end
            default: begin
                nxt_rst_state = RST_IDLE;
            end
        endcase
        // A new serial write restarts the pulse at full length
        if (force_wr) begin
            nxt_rst_state = RST_PULSE;
            nxt_rst_cnt = RESET_PULSE_CYCLES - 4'h1;
        end
        nxt_rst = (nxt_rst_state == RST_PULSE);
    end

    // Register the forced reset sequencing
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rst_state_ff <= RST_IDLE;
            rst_cnt_ff <= 4'h0;
            rst_ff <= 1'b0;
        end else begin
            rst_state_ff <= nxt_rst_state;
            rst_cnt_ff <= nxt_rst_cnt;
            rst_ff <= nxt_rst;
        end
    end

    // Read multiplexer; unselected and refused reads give zero
    always_comb begin
        nxt_rvalid = ser_rd;
        nxt_rdata = READ_ZERO;
        if (ser_rd && hit(ser_idx, IDX_STATUS_CONTROL)) begin
            nxt_rdata[BIT_BKPT_EN] = bkpt_en_ff;
            nxt_rdata[BIT_FORCE_TAG] = force_tag_ff;
            nxt_rdata[BIT_LOWPOWER] = cpu_lowpower || lp_hold_ff;
            nxt_rdata[BIT_LP_FAIL] = lp_fail_ff;
            nxt_rdata[BIT_SLOW_FAIL] = slow_fail_ff;
        end
        if (rd_pair) begin
            nxt_rdata = pair_rdata;
        end
        // Force-reset register always reads zero
        if (ser_rd && hit(ser_idx, IDX_FORCE_RESET)) begin
            nxt_rdata = READ_ZERO;
        end
    end

    // Register the read port
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rdata_ff <= REG_RESET;
            rvalid_ff <= 1'b0;
        end else begin
            rdata_ff <= nxt_rdata;
            rvalid_ff <= nxt_rvalid;
        end
    end

    // Every output comes straight from a flip-flop
    assign ser_rdata = rdata_ff;
    assign ser_rvalid = rvalid_ff;
    assign bkpt_force_req = bkpt_force_ff;
    assign bkpt_tag = bkpt_tag_ff;
    assign bkpt_tag_enter = tag_enter_ff;
    assign mcu_reset_req = rst_ff;
endmodule // bkpt_status_ctrl

// file: common/bkpt_status_pkg.sv
// Constants shared by the background debug breakpoint/status block.
// Assumes a byte-wide register port driven by the serial command decoder.
package bkpt_status_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int REG_IDX_W = 2;
    // Register indices on the serial register port
    localparam logic [1:0] IDX_STATUS_CONTROL = 2'h0;
    localparam logic [1:0] IDX_BKPT_HIGH = 2'h1;
    localparam logic [1:0] IDX_BKPT_LOW = 2'h2;
    localparam logic [1:0] IDX_FORCE_RESET = 2'h3;
    // Status/control field positions
    localparam int BIT_BKPT_EN = 5;
    localparam int BIT_FORCE_TAG = 4;
    localparam int BIT_LOWPOWER = 2;
    localparam int BIT_LP_FAIL = 1;
    localparam int BIT_SLOW_FAIL = 0;
    localparam int BIT_FORCE_RESET = 0;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] READ_ZERO = 8'h00;
    // Length of the forced reset pulse in cycles
    localparam logic [3:0] RESET_PULSE_CYCLES = 4'h8;
endpackage

// file: core/bkpt_pair_reg.sv
// Breakpoint address pair storage with a byte read port.
// Assumes the parent decodes which byte is written or read.
`timescale 1ns/1ps
module bkpt_pair_reg (
    input wire logic mclk, // Clock
    input wire logic rstn, // Async reset, active low
    input wire logic wr_high, // Write high byte
    input wire logic wr_low, // Write low byte
    input wire logic [7:0] wdata, // Write data
    input wire logic rd_low_sel, // Read selects low byte
    output logic [7:0] rdata, // Selected byte, registered by the parent
    output logic [15:0] addr // Stored breakpoint address
);
    import bkpt_status_pkg::*;
    logic [7:0] high_ff, low_ff;
    logic [7:0] nxt_high, nxt_low;

    // Next values for the pair
    always_comb begin
        nxt_high = high_ff;
        nxt_low = low_ff;
        if (wr_high) begin
            nxt_high = wdata;
        end
        if (wr_low) begin
            nxt_low = wdata;
        end
    end

    // Register the pair
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            high_ff <= REG_RESET;
            low_ff <= REG_RESET;
        end else begin
            high_ff <= nxt_high;
            low_ff <= nxt_low;
        end
    end

    // Byte select; the parent registers it so its read data leave from a flip-flop
    assign rdata = rd_low_sel ? low_ff : high_ff;
    assign addr = {high_ff, low_ff};
endmodule // bkpt_pair_reg

// file: verification/bkpt_status_sva.sv
// Checker for the breakpoint/status block, bound to its top module.
// Assumes one clock mclk and an active-low asynchronous reset rstn.
`timescale 1ns/1ps
module bkpt_status_sva (
    input wire logic mclk, rstn, ser_wr, ser_rd, ser_bkpt_cmd,
    input wire logic [1:0] ser_idx,
    input wire logic [7:0] ser_wdata, ser_rdata,
    input wire logic ser_rvalid, user_wr_force_reset, cpu_lowpower, cpu_fetch,
    input wire logic cpu_boundary, tagged_exec, bkpt_force_req, bkpt_tag,
    input wire logic bkpt_tag_enter, mcu_reset_req
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    // Register port answers and read values
    a_read_answer: assert property (ser_rd |=> ser_rvalid) else $error("read unanswered");
    a_no_stray: assert property (!ser_rd |=> !ser_rvalid) else $error("stray read valid");
    a_force_reads_zero: assert property (ser_rd && ser_idx == 2'h3 |=> ser_rdata == 8'h00)
        else $error("force reset read not zero");
    a_status_reserved: assert property (ser_rd && ser_idx == 2'h0 |=> ser_rdata[7:6] == 2'h0 && !ser_rdata[3])
        else $error("status reserved bit set");
    a_bkpt_guarded: assert property (ser_rd && !ser_bkpt_cmd && ser_idx inside {2'h1, 2'h2} |=> ser_rdata == 8'h00)
        else $error("breakpoint read without command");
    a_lowpower_seen: assert property (ser_rd && ser_idx == 2'h0 && cpu_lowpower |=> ser_rdata[2])
        else $error("low power flag missing");
    // Forced reset pulse, its cause and the ignored user write
    a_reset_length: assert property ($rose(mcu_reset_req) |-> mcu_reset_req[*8] ##1 !mcu_reset_req)
        else $error("reset pulse length wrong");
    a_reset_cause: assert property ($rose(mcu_reset_req) |-> $past(ser_wr)) else $error("reset without write");
    a_reset_follows: assert property (ser_wr && ser_idx == 2'h3 && ser_wdata[0] |=> mcu_reset_req)
        else $error("reset not raised");
    a_user_ignored: assert property (user_wr_force_reset && !ser_wr && !mcu_reset_req |=> !mcu_reset_req)
        else $error("user write caused reset");
    // Breakpoint outputs follow their causes
    a_tag_cause: assert property (bkpt_tag |-> $past(cpu_fetch)) else $error("tag without fetch");
    a_enter_cause: assert property (bkpt_tag_enter |-> $past(tagged_exec)) else $error("enter untagged");
    a_force_cause: assert property (bkpt_force_req |-> $past(cpu_boundary)) else $error("force off boundary");
    c_force: cover property (bkpt_force_req);
    c_enter: cover property (bkpt_tag_enter);
    c_reset: cover property ($rose(mcu_reset_req));
    c_tag: cover property (bkpt_tag);
endmodule // bkpt_status_sva

bind bkpt_status_ctrl bkpt_status_sva u_sva (.mclk, .rstn, .ser_wr, .ser_rd, .ser_bkpt_cmd, .ser_idx, .ser_wdata,
    .ser_rdata, .ser_rvalid, .user_wr_force_reset, .cpu_lowpower, .cpu_fetch, .cpu_boundary, .tagged_exec,
    .bkpt_force_req, .bkpt_tag, .bkpt_tag_enter, .mcu_reset_req);

// file: verification/debug_host.sv
// Debug host model issuing serial register commands.
// Assumes the bench calls cmd; lines change on falling edges only.
`timescale 1ns/1ps
module debug_host (
    input wire logic mclk, // Clock
    output logic ser_wr, ser_rd, ser_bkpt_cmd, // Strobes and qualifier
    output logic [1:0] ser_idx, // Register index
    output logic [7:0] ser_wdata // Write data
);
    initial {ser_wr, ser_rd, ser_bkpt_cmd, ser_idx, ser_wdata} = '0;
    // One command held over one rising edge; released lines show inverted junk
    task automatic cmd(input logic w, input logic [1:0] i, input logic [7:0] d, input logic b);
        @(negedge mclk);
        {ser_wr, ser_rd, ser_idx, ser_wdata, ser_bkpt_cmd} = {w, !w, i, d, b};
        @(negedge mclk);
        {ser_wr, ser_rd, ser_idx, ser_wdata, ser_bkpt_cmd} = {2'b00, ~i, ~d, 1'b0};
    endtask
endmodule // debug_host

// file: verification/testbench.sv
// Self-checking bench for the breakpoint/status block.
// Assumes the debug host model drives the serial register port.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module testbench;
    import bkpt_status_pkg::*;
    logic mclk, rstn, ser_wr, ser_rd, ser_bkpt_cmd, ser_rvalid, user_wr_force_reset, cpu_lowpower, bg_entry, bg_exit;
    logic access_fail_lowpower, access_fail_slow, access_start, cpu_fetch, cpu_boundary, tagged_exec;
    logic bkpt_force_req, bkpt_tag, bkpt_tag_enter, mcu_reset_req;
    logic [1:0] ser_idx;
    logic [7:0] ser_wdata, ser_rdata, exp_v;
    logic [15:0] cpu_addr, a;
    logic [7:0] q[$];
    int n_fail, n_tests, seed;
    int cnt[4];
    bkpt_status_ctrl DUT (.mclk(mclk), .rstn(rstn), .ser_wr(ser_wr), .ser_rd(ser_rd), .ser_bkpt_cmd(ser_bkpt_cmd),
        .ser_idx(ser_idx), .ser_wdata(ser_wdata), .ser_rdata(ser_rdata), .ser_rvalid(ser_rvalid),
        .user_wr_force_reset(user_wr_force_reset), .cpu_lowpower(cpu_lowpower), .bg_entry(bg_entry),
        .bg_exit(bg_exit), .access_fail_lowpower(access_fail_lowpower), .access_fail_slow(access_fail_slow),
        .access_start(access_start), .cpu_addr(cpu_addr), .cpu_fetch(cpu_fetch), .cpu_boundary(cpu_boundary),
        .tagged_exec(tagged_exec), .bkpt_force_req(bkpt_force_req), .bkpt_tag(bkpt_tag),
        .bkpt_tag_enter(bkpt_tag_enter), .mcu_reset_req(mcu_reset_req));
    debug_host host (.mclk(mclk), .ser_wr(ser_wr), .ser_rd(ser_rd), .ser_bkpt_cmd(ser_bkpt_cmd),
        .ser_idx(ser_idx), .ser_wdata(ser_wdata));
    initial begin
        mclk = 0;
        forever #10 mclk = ~mclk;
    end
    // Read results come off the queue in order
    always @(negedge mclk) if (ser_rvalid === 1'b1) begin
        exp_v = q.size() ? q.pop_front() : 8'hxx;
        `CHK("read data", exp_v, ser_rdata)
    end
    // Output pulse counts sampled on falling edges; reset request counts its high cycles
    always @(negedge mclk) begin
        `CHK("outputs known", 1'b0, $isunknown({bkpt_force_req, bkpt_tag, bkpt_tag_enter, mcu_reset_req, ser_rvalid}))
        cnt[0] += bkpt_force_req;
        cnt[1] += bkpt_tag;
        cnt[2] += bkpt_tag_enter;
        cnt[3] += mcu_reset_req;
    end
    task rd(input logic [1:0] i, input logic b, input logic [7:0] e);
        q.push_back(e);
        host.cmd(1'b0, i, 8'h00, b);
    endtask
    // Pulse vector: user write, entry, exit, lp fail, slow fail, start, tagged
    task cpu(input logic [6:0] v);
        @(negedge mclk);
        {user_wr_force_reset, bg_entry, bg_exit, access_fail_lowpower, access_fail_slow, access_start, tagged_exec} = v;
        @(negedge mclk);
        {user_wr_force_reset, bg_entry, bg_exit, access_fail_lowpower, access_fail_slow, access_start, tagged_exec} = '0;
    endtask
    task bus(input logic f, input logic b);
        @(negedge mclk);
        {cpu_addr, cpu_fetch, cpu_boundary} = {a, f, b};
        @(negedge mclk);
        {cpu_addr, cpu_fetch, cpu_boundary} = {~a, 2'b00};
        repeat (3) @(negedge mclk);
    endtask
    task chkp(input int f, input int t, input int e, input int r);
        @(posedge mclk);
        `CHK("force pulses", f, cnt[0])
        `CHK("tag pulses", t, cnt[1])
        `CHK("enter pulses", e, cnt[2])
        `CHK("reset cycles", r, cnt[3])
    endtask
    task wrap_up;
        $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        seed = 48284;
        rstn = 0;
        {user_wr_force_reset, bg_entry, bg_exit, access_fail_lowpower, access_fail_slow, access_start} = '0;
        {cpu_lowpower, cpu_addr, cpu_fetch, cpu_boundary, tagged_exec} = '0;
        repeat (5) @(posedge mclk);
        @(negedge mclk) rstn = 1;
        for (int i = 0; i < 4; i++) rd(2'(i), 1'b1, 8'h00);
        // Breakpoint pair through breakpoint commands only, user program running
        repeat (4) begin
            a = 16'($random(seed));
            host.cmd(1'b1, 2'h1, a[15:8], 1'b1);
            host.cmd(1'b1, 2'h2, a[7:0], 1'b1);
            host.cmd(1'b1, 2'h1, ~a[15:8], 1'b0);
            rd(2'h1, 1'b1, a[15:8]);
            rd(2'h2, 1'b1, a[7:0]);
            rd(2'h2, 1'b0, 8'h00);
        end
        // Status control bits and failure flags
        host.cmd(1'b1, 2'h0, 8'hff, 1'b0);
        rd(2'h0, 1'b0, 8'h30);
        cpu(7'h08);
        rd(2'h0, 1'b0, 8'h32);
        cpu(7'h20);
        cpu(7'h02);
        rd(2'h0, 1'b0, 8'h30);
        cpu(7'h04);
        rd(2'h0, 1'b0, 8'h31);
        cpu(7'h02);
        rd(2'h0, 1'b0, 8'h30);
        cpu(7'h06);
        rd(2'h0, 1'b0, 8'h31);
        cpu(7'h02);
        @(negedge mclk) cpu_lowpower = 1;
        rd(2'h0, 1'b0, 8'h34);
        cpu(7'h20);
        @(negedge mclk) cpu_lowpower = 0;
        rd(2'h0, 1'b0, 8'h34);
        cpu(7'h10);
        rd(2'h0, 1'b0, 8'h30);
        // Force, tag, then disabled breakpoint at the stored address
        bus(1'b0, 1'b1);
        chkp(1, 0, 0, 0);
        host.cmd(1'b1, 2'h0, 8'h20, 1'b0);
        bus(1'b1, 1'b0);
        cpu(7'h01);
        chkp(1, 1, 1, 0);
        host.cmd(1'b1, 2'h0, 8'h00, 1'b0);
        bus(1'b1, 1'b1);
        cpu(7'h01);
        chkp(1, 1, 1, 0);
        // User write ignored, bit 0 clear does nothing, bit 0 set resets
        cpu(7'h40);
        host.cmd(1'b1, 2'h3, 8'hfe, 1'b1);
        repeat (12) @(negedge mclk);
        chkp(1, 1, 1, 0);
        host.cmd(1'b1, 2'h3, 8'h01, 1'b1);
        repeat (12) @(negedge mclk);
        chkp(1, 1, 1, 8);
        rd(2'h3, 1'b1, 8'h00);
        for (int k = 0; k < 20 && q.size() > 0; k++) @(negedge mclk);
        if (q.size() > 0) n_fail++;
        wrap_up();
    end
endmodule // testbench
